// ===== sbd_pkg.sv
// How it works
// - Software seeds the toggle bit; hardware writes back the toggle it reaches.
// - Each no-response or bad-response error decrements the error count; zero clears valid.
// - A NAK or NYET restores the error count to its loaded value.
// - Valid clears when the NAK countdown reaches zero with a non-zero reload.
// - Hardware records the bytes actually moved in the bytes_done field.
// - A zero reload makes hardware ignore the NAK countdown entirely.
// - buffer_start is an internal address, (processor address minus 400h) divided by 8.
// - speed_end_sel is used only for split transfers, ignored for high-speed.
// - A set retire bit abandons the descriptor; no further transfers run.
// - Valid clears when the descriptor completes or a fatal error occurs.
// - The split bit selects a plain high-speed or a start/complete split transfer.
package sbd_pkg;
  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [5:0] STATUS_OFF = 6'h20;
  localparam logic [5:0] MASK_OFF = 6'h24;
  localparam logic [5:0] DW3_OFF = 6'h0C;
  localparam int DESC_WORDS = 8;
  // ************************************************************
  // Descriptor field positions
  // ************************************************************
  localparam int VALID_B = 0;
  localparam int XLEN_LO = 3;
  localparam int MPL_LO = 18;
  localparam int SPLIT_B = 14;
  localparam int RETIRE_B = 15;
  localparam int SPEED_END_LO = 16;
  localparam int PORT_LO = 18;
  localparam int HUB_LO = 25;
  localparam int BUF_LO = 8;
  localparam int RELOAD_LO = 25;
  localparam int ACTIVE_B = 31;
  localparam int HALT_B = 30;
  localparam int BABBLE_B = 29;
  localparam int XERR_B = 28;
  localparam int SC_B = 27;
  localparam int TOG_B = 25;
  localparam int CERR_LO = 23;
  localparam int NAK_LO = 19;
  // ************************************************************
  // Handshake outcomes and interrupt events
  // ************************************************************
  localparam logic [2:0] HS_ACK = 3'h0;
  localparam logic [2:0] HS_NAK = 3'h1;
  localparam logic [2:0] HS_NYET = 3'h2;
  localparam logic [2:0] HS_NORESP = 3'h3;
  localparam logic [2:0] HS_BAD = 3'h4;
  localparam logic [2:0] HS_BABBLE = 3'h5;
  localparam logic [2:0] HS_STALL = 3'h6;
  localparam int EV_DONE = 0;
  localparam int EV_ERR = 1;
  localparam int EV_NAKOUT = 2;
  localparam int EV_RETIRED = 3;
  localparam logic [3:0] STATUS_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
endpackage

// ===== split_bulk_descriptor_engine.sv
`timescale 1ns/1ps
module split_bulk_descriptor_engine (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic hs_valid,
  input wire logic [2:0] hs_code,
  input wire logic [14:0] hs_bytes,
  output logic xfer_req,
  output logic xfer_split,
  output logic xfer_cs,
  output logic xfer_toggle,
  output logic [15:0] xfer_buf,
  output logic [1:0] xfer_speed_end,
  output logic [6:0] xfer_hub_addr,
  output logic [6:0] xfer_hub_port
);
  // ************************************************************
  // Descriptor store and fields
  // ************************************************************
  logic [31:0] desc [0:7];
  logic [3:0] status;
  logic [3:0] mask;
  logic [1:0] cerr_load;
  logic wr_pend;
  logic [5:0] wr_addr;
  logic rd_pend;
  logic [5:0] rd_addr;
  logic rd_ok;
  logic valid, active, retire, split, sc, tog, halt;
  logic [1:0] cerr;
  logic [3:0] nak, reload;
  logic [14:0] done, xlen;
  logic [10:0] maxpkt;
  logic [14:0] sum;
  logic next_valid, next_active, next_sc, next_tog, next_halt, next_babble, next_xerr;
  logic [1:0] next_cerr;
  logic [3:0] next_nak, ev;
  logic [14:0] next_done;

  assign valid = desc[0][sbd_pkg::VALID_B];
  assign xlen = desc[0][sbd_pkg::XLEN_LO +: 15];
  assign maxpkt = desc[0][sbd_pkg::MPL_LO +: 11];
  assign split = desc[1][sbd_pkg::SPLIT_B];
  assign retire = desc[1][sbd_pkg::RETIRE_B];
  assign reload = desc[2][sbd_pkg::RELOAD_LO +: 4];
  assign active = desc[3][sbd_pkg::ACTIVE_B];
  assign halt = desc[3][sbd_pkg::HALT_B];
  assign sc = desc[3][sbd_pkg::SC_B];
  assign tog = desc[3][sbd_pkg::TOG_B];
  assign cerr = desc[3][sbd_pkg::CERR_LO +: 2];
  assign nak = desc[3][sbd_pkg::NAK_LO +: 4];
  assign done = desc[3][14:0];
  assign sum = 15'(done + hs_bytes);

  function automatic logic [31:0] read_word(input logic [5:0] a);
    logic [31:0] r;
    r = 32'h0;
    if (a < 6'(sbd_pkg::DESC_WORDS * 4)) begin
      r = desc[a[4:2]];
    end else if (a == sbd_pkg::STATUS_OFF) begin
      r = {28'h0, status};
    end else if (a == sbd_pkg::MASK_OFF) begin
      r = {28'h0, mask};
    end
    return r;
  endfunction

  // ************************************************************
  // Transfer engine
  // ************************************************************
  // Computes the descriptor write-back for one handshake outcome.
  always_comb begin
    next_valid = valid;
    next_active = active;
    next_sc = sc;
    next_tog = tog;
    next_halt = halt;
    next_babble = desc[3][sbd_pkg::BABBLE_B];
    next_xerr = desc[3][sbd_pkg::XERR_B];
    next_cerr = cerr;
    next_nak = nak;
    next_done = done;
    ev = 4'h0;
    if (retire && valid) begin
      next_valid = 1'b0;
      next_active = 1'b0;
      ev[sbd_pkg::EV_RETIRED] = 1'b1;
    end else if (hs_valid && valid) begin
      case (hs_code)
        sbd_pkg::HS_ACK: begin
          next_cerr = cerr_load;
          if (split && !sc) begin
            next_sc = 1'b1;
          end else begin
            next_sc = 1'b0;
            next_tog = ~tog;
            next_done = sum;
            if (sum >= xlen || hs_bytes < {4'h0, maxpkt}) begin
              next_valid = 1'b0;
              next_active = 1'b0;
              ev[sbd_pkg::EV_DONE] = 1'b1;
            end
          end
        end
        sbd_pkg::HS_NAK: begin
          next_cerr = cerr_load;
          next_sc = 1'b0;
          if (reload != 4'h0) begin
            next_nak = nak - 4'h1;
            if (nak == 4'h1) begin
              next_valid = 1'b0;
              next_active = 1'b0;
              ev[sbd_pkg::EV_NAKOUT] = 1'b1;
            end
          end
        end
        sbd_pkg::HS_NYET: begin
          next_cerr = cerr_load;
        end
        sbd_pkg::HS_NORESP, sbd_pkg::HS_BAD: begin
          if (cerr != 2'h0) begin
            next_cerr = cerr - 2'h1;
          end
          if (cerr <= 2'h1) begin
            next_valid = 1'b0;
            next_active = 1'b0;
            next_xerr = 1'b1;
            next_halt = 1'b1;
            ev[sbd_pkg::EV_ERR] = 1'b1;
          end
        end
        sbd_pkg::HS_BABBLE, sbd_pkg::HS_STALL: begin
          next_valid = 1'b0;
          next_active = 1'b0;
          next_halt = 1'b1;
          next_babble = (hs_code == sbd_pkg::HS_BABBLE);
          ev[sbd_pkg::EV_ERR] = 1'b1;
        end
        default: begin
        end
      endcase
    end
  end

  // A software write in its data phase overrides the engine for that word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < sbd_pkg::DESC_WORDS; i++) begin
        desc[i] <= 32'h0;
      end
    end else begin
      desc[0] <= {desc[0][31:1], next_valid};
      desc[3] <= {next_active, next_halt, next_babble, next_xerr, next_sc, desc[3][26], next_tog,
                  next_cerr, next_nak, desc[3][18:15], next_done};
      if (wr_pend && wr_addr < 6'(sbd_pkg::DESC_WORDS * 4)) begin
        desc[wr_addr[4:2]] <= hwdata;
      end
    end
  end

  // Captures the error count that software loads, for restoring on NAK or NYET.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cerr_load <= 2'h0;
    end else if (wr_pend && wr_addr == sbd_pkg::DW3_OFF) begin
      cerr_load <= hwdata[sbd_pkg::CERR_LO +: 2];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      xfer_req <= 1'b0;
      xfer_split <= 1'b0;
      xfer_cs <= 1'b0;
      xfer_toggle <= 1'b0;
      xfer_buf <= 16'h0;
      xfer_speed_end <= 2'h0;
      xfer_hub_addr <= 7'h0;
      xfer_hub_port <= 7'h0;
    end else begin
      xfer_req <= valid && active && !retire && !halt;
      xfer_split <= split;
      xfer_cs <= split && sc;
      xfer_toggle <= tog;
      xfer_buf <= desc[2][sbd_pkg::BUF_LO +: 16];
      xfer_speed_end <= split ? desc[1][sbd_pkg::SPEED_END_LO +: 2] : 2'h0;
      xfer_hub_addr <= desc[1][sbd_pkg::HUB_LO +: 7];
      xfer_hub_port <= desc[1][sbd_pkg::PORT_LO +: 7];
    end
  end

  // ************************************************************
  // AHB-Lite slave
  // ************************************************************
  // Reads take one wait state so a write just before them is already stored.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 6'h0;
      rd_pend <= 1'b0;
      rd_addr <= 6'h0;
      rd_ok <= 1'b0;
    end else begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      if (hsel && htrans[1] && hready && hreadyout) begin
        wr_pend <= hwrite && (haddr[31:6] == 26'h0);
        wr_addr <= haddr[5:0];
        rd_pend <= !hwrite;
        rd_addr <= haddr[5:0];
        rd_ok <= haddr[31:6] == 26'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      hreadyout <= !(hsel && htrans[1] && hready && hreadyout && !hwrite);
      if (rd_pend) begin
        hrdata <= rd_ok ? read_word(rd_addr) : 32'h0;
      end
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  // A read of the status word clears it; a new event in that cycle still sets.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status <= sbd_pkg::STATUS_RST;
    end else if (rd_pend && rd_ok && rd_addr == sbd_pkg::STATUS_OFF) begin
      status <= ev;
    end else begin
      status <= status | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask <= sbd_pkg::MASK_RST;
    end else if (wr_pend && wr_addr == sbd_pkg::MASK_OFF) begin
      mask <= hwdata[3:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status & mask);
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  logic quiet;
  assign quiet = hs_valid && valid && !retire && !wr_pend;

  err_retire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && (hs_code == sbd_pkg::HS_NORESP || hs_code == sbd_pkg::HS_BAD) && cerr == 2'h1
    |=> !valid && cerr == 2'h0 ##1 !xfer_req)
    else $error("error count end did not retire");
  cerr_restore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && (hs_code == sbd_pkg::HS_NAK || hs_code == sbd_pkg::HS_NYET)
    |=> cerr == $past(cerr_load))
    else $error("error count not restored");
  nak_retire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && hs_code == sbd_pkg::HS_NAK && reload != 4'h0 && nak == 4'h1 |=> !valid && !active)
    else $error("nak countdown end did not retire");
  nak_ignore_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && hs_code == sbd_pkg::HS_NAK && reload == 4'h0 |=> valid && $stable(nak))
    else $error("nak counted with zero reload");
  nak_step_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && hs_code == sbd_pkg::HS_NAK && reload != 4'h0 && nak > 4'h1
    |=> nak == 4'($past(nak) - 4'h1))
    else $error("nak countdown did not step");
  bytes_done_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && hs_code == sbd_pkg::HS_ACK && (!split || sc)
    |=> done == 15'($past(done) + $past(hs_bytes)) && tog != $past(tog))
    else $error("bytes or toggle not written back");
  split_phase_a: assert property (@(posedge hclk) disable iff (!hresetn)
    quiet && hs_code == sbd_pkg::HS_ACK && split && !sc |=> sc ##1 xfer_cs)
    else $error("start split did not advance");
  retire_a: assert property (@(posedge hclk) disable iff (!hresetn)
    retire && valid && !wr_pend |=> !valid ##1 !xfer_req)
    else $error("retired descriptor still live");
  speed_end_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !split |=> xfer_speed_end == 2'h0)
    else $error("speed select used without split");
  read_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rd_pend |-> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
endmodule

// ===== tb_top.sv
`timescale 1ns/1ps
// ************************************************************
// Bench for the split bulk descriptor engine
// ************************************************************
module tb_top;
  logic hclk = 1'h0;
  logic hresetn = 1'h0;
  logic hsel = 1'h0;
  logic hwrite = 1'h0;
  logic go = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [2:0] code = 3'h0;
  logic [2:0] hs_code;
  logic [14:0] nb = 15'h0;
  logic [14:0] hs_bytes;
  logic hreadyout, hresp, irq, hs_valid, xfer_req, xfer_split, xfer_cs, xfer_toggle;
  logic [15:0] xfer_buf;
  logic [1:0] xfer_speed_end;
  logic [6:0] xfer_hub_addr, xfer_hub_port;
  logic [2:0] ec [5];
  logic [1:0] ev [5];
  int n_mismatch = 0;
  int check_count = 0;
  always #12.5 hclk = ~hclk;
  split_bulk_descriptor_engine u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .hs_valid(hs_valid), .hs_code(hs_code), .hs_bytes(hs_bytes), .xfer_req(xfer_req),
    .xfer_split(xfer_split), .xfer_cs(xfer_cs), .xfer_toggle(xfer_toggle), .xfer_buf(xfer_buf),
    .xfer_speed_end(xfer_speed_end), .xfer_hub_addr(xfer_hub_addr), .xfer_hub_port(xfer_hub_port));
  tt_partner u_tt (.hclk(hclk), .hresetn(hresetn), .go(go), .code(code), .nbytes(nb), .xfer_req(xfer_req),
    .hs_valid(hs_valid), .hs_code(hs_code), .hs_bytes(hs_bytes));
  task automatic summarize();
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [31:0] xv();
    return {12'h0, xfer_req, xfer_split, xfer_cs, xfer_toggle, xfer_speed_end, xfer_hub_addr, xfer_hub_port};
  endfunction
  // Ready is registered, so its level at the falling edge is what the next rising edge samples.
  task automatic rdy();
    do @(negedge hclk); while (hreadyout !== 1'h1);
    r = hrdata;
    @(posedge hclk);
  endtask
  task automatic wr(logic [31:0] a, logic [31:0] d);
    hsel <= 1'h1; haddr <= a; hwrite <= 1'h1; htrans <= 2'h2;
    rdy();
    htrans <= 2'h0; hwdata <= d;
    rdy();
  endtask
  task automatic rc(string n, logic [31:0] a, logic [31:0] m, logic [31:0] e);
    hsel <= 1'h1; haddr <= a; hwrite <= 1'h0; htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    rdy();
    chk(n, e, r & m);
  endtask
  task automatic hs(logic [2:0] c, logic [14:0] b);
    code <= c; nb <= b; go <= 1'h1;
    @(posedge hclk);
    go <= 1'h0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic setup(logic [31:0] w1, logic [31:0] w2, logic [31:0] w3);
    wr(32'h4, w1); wr(32'h8, w2); wr(32'hC, w3); wr(32'h0, 32'h01000321);
    repeat (2) @(posedge hclk);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_mismatch++;
    summarize();
  end
  initial begin
    ec = '{sbd_pkg::HS_NORESP, sbd_pkg::HS_NYET, sbd_pkg::HS_BAD, sbd_pkg::HS_NAK, sbd_pkg::HS_NORESP};
    ev = '{2'h1, 2'h2, 2'h1, 2'h2, 2'h1};
    repeat (6) @(posedge hclk);
    hresetn <= 1'h1;
    // Buffer 1234h stands for processor address 91A0h + 400h.
    setup(32'h54164000, 32'h00123400, 32'h83800000);
    chk("xfer", {12'h0, 4'hD, 2'h2, 7'h2A, 7'h05}, xv());
    chk("buf", 32'h1234, {16'h0, xfer_buf});
    hs(sbd_pkg::HS_ACK, 15'h0);
    chk("xfer", {12'h0, 4'hF, 2'h2, 7'h2A, 7'h05}, xv());
    hs(sbd_pkg::HS_ACK, 15'h40);
    chk("xfer", {12'h0, 4'hC, 2'h2, 7'h2A, 7'h05}, xv());
    rc("dw3", 32'hC, 32'h83807FFF, 32'h81800040);
    hs(sbd_pkg::HS_ACK, 15'h0);
    hs(sbd_pkg::HS_ACK, 15'h24);
    rc("dw3", 32'hC, 32'h83807FFF, 32'h03800064);
    rc("valid", 32'h0, 32'h1, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(32'h24, 32'hF);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h1, {31'h0, irq});
    rc("status", 32'h20, 32'hF, 32'h1);
    repeat (2) @(posedge hclk);
    chk("irq", 32'h0, {31'h0, irq});
    rc("status", 32'h20, 32'hF, 32'h0);
    rc("unmapped", 32'h30, 32'hFFFFFFFF, 32'h0);
    setup(32'h00004000, 32'h0, 32'h81000000);
    for (int i = 0; i < 5; i++) begin
      hs(ec[i], 15'h0);
      rc("cerr", 32'hC, 32'h01800000, {7'h0, ev[i], 23'h0});
    end
    hs(sbd_pkg::HS_BAD, 15'h0);
    rc("halt", 32'hC, 32'hD0780000, 32'h50000000);
    rc("valid", 32'h0, 32'h1, 32'h0);
    rc("status", 32'h20, 32'hF, 32'h2);
    setup(32'h00030000, 32'h04000000, 32'h83900000);
    chk("xfer", {12'h0, 4'h9, 2'h0, 14'h0}, xv());
    hs(sbd_pkg::HS_NAK, 15'h0);
    rc("nak_countdown", 32'hC, 32'h00780000, 32'h00080000);
    rc("valid", 32'h0, 32'h1, 32'h1);
    hs(sbd_pkg::HS_NAK, 15'h0);
    rc("valid", 32'h0, 32'h1, 32'h0);
    rc("status", 32'h20, 32'hF, 32'h4);
    setup(32'h0000C000, 32'h0, 32'h81800000);
    chk("req", 32'h0, {31'h0, xfer_req});
    rc("valid", 32'h0, 32'h1, 32'h0);
    rc("status", 32'h20, 32'hF, 32'h8);
    setup(32'h0, 32'h0, 32'h80000000);
    hs(sbd_pkg::HS_BABBLE, 15'h0);
    rc("babble", 32'hC, 32'hF0000000, 32'h60000000);
    rc("status", 32'h20, 32'hF, 32'h2);
    setup(32'h0, 32'h0, 32'h80000000);
    hs(sbd_pkg::HS_STALL, 15'h0);
    rc("stall", 32'hC, 32'hF0000000, 32'h40000000);
    rc("valid", 32'h0, 32'h1, 32'h0);
    rc("status", 32'h20, 32'hF, 32'h2);
    chk("hresp", 32'h0, {31'h0, hresp});
    summarize();
  end
endmodule

// ===== tt_partner.sv
`timescale 1ns/1ps
// ************************************************************
// Translator and downstream function: one handshake per request
// ************************************************************
module tt_partner (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [2:0] code,
  input wire logic [14:0] nbytes,
  input wire logic xfer_req,
  output logic hs_valid,
  output logic [2:0] hs_code,
  output logic [14:0] hs_bytes
);
  // Outside a handshake the code and byte lines flip every cycle, so stale values are never mistaken for answers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hs_valid <= 1'h0;
      hs_code <= 3'h0;
      hs_bytes <= 15'h0;
    end else if (go && xfer_req) begin
      hs_valid <= 1'h1;
      hs_code <= code;
      hs_bytes <= nbytes;
    end else begin
      hs_valid <= 1'h0;
      hs_code <= ~hs_code;
      hs_bytes <= ~hs_bytes;
    end
  end
endmodule
